// File: design/ced_pkg.sv
/*
  ced_pkg: constants, register map and carrier types of the console
  examine/deposit sequencer.
  Assumes a 16-bit word memory with byte addressing and a 32-bit
  Avalon-MM register bus driven by a single master.
*/
package ced_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int AVS_DW = 32;
  localparam int AVS_AW = 5;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [AVS_AW-1:0] OFF_CTRL = 5'h00;
  localparam logic [AVS_AW-1:0] OFF_STATUS = 5'h04;
  localparam logic [AVS_AW-1:0] OFF_ADDR = 5'h08;
  localparam logic [AVS_AW-1:0] OFF_DATA = 5'h0c;
  localparam logic [AVS_AW-1:0] OFF_SWITCH = 5'h10;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_KEY_LSB = 4;
  localparam int STAT_OWN_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_OP_LSB = 4;
  localparam logic CTRL_LOCK_RST = 1'b0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // ----------------------------------------
  // address stepping
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;
  localparam logic [ADDR_W-1:0] REG_STEP = 16'h0001;
  localparam logic [ADDR_W-1:0] REGS_LO = 16'hffc0;
  localparam logic [ADDR_W-1:0] REGS_HI = 16'hffcf;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_DEP = 3'b010,
    S_EXAMINE_KEY = 3'b100
  } ced_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b001,
    OP_DEP = 3'b010,
    OP_EXAMINE_KEY = 3'b100
  } ced_op_t;

  typedef struct packed {
    logic examineKey;
    logic depositKey;
    logic loadAddressKey;
  } ced_keys_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writeData;
  } ced_mem_req_t;

  typedef struct packed {
    ced_mem_req_t req;
    logic done;
    logic [DATA_W-1:0] rdata;
  } ced_mst_t;

endpackage

// File: design/ced_mem_master.sv
/*
  ced_mem_master: performs one word read or write on the memory bus
  (Avalon-MM master signalling, held until waitrequest is low).
  Assumes start is only pulsed while the previous transfer is done.
*/
`timescale 1ns/1ps
module ced_mem_master
  import ced_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic writeOp,
  input wire logic [ced_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [ced_pkg::DATA_W-1:0] reqData,
  output logic done,
  output logic [ced_pkg::DATA_W-1:0] readData,
  output ced_pkg::ced_mem_req_t memReq,
  input wire logic [ced_pkg::DATA_W-1:0] memReadData,
  input wire logic memWaitrequest
);
  import ced_pkg::*;

  ced_mst_t st_ff;
  ced_mst_t nxt_st;
  logic busy;

  assign busy = st_ff.req.read | st_ff.req.write;

  // ----------------------------------------
  // transfer sequencing
  // ----------------------------------------
  // request held until accepted, then a one-cycle done
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (busy && !memWaitrequest)
    begin
      nxt_st.req.read = 1'b0;
      nxt_st.req.write = 1'b0;
      nxt_st.done = 1'b1;
      if (st_ff.req.read)
      begin
        nxt_st.rdata = memReadData;
      end
    end
    else if (start && !busy)
    begin
      nxt_st.req.read = ~writeOp;
      nxt_st.req.write = writeOp;
      nxt_st.req.address = reqAddr;
      nxt_st.req.writeData = reqData;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign memReq = st_ff.req;
  assign done = st_ff.done;
  assign readData = st_ff.rdata;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_req_held: assert property (@(posedge sys_clk) disable iff (!rstn)
    busy && memWaitrequest |=> $stable(memReq))
    else $error("memory request changed while stalled");

  chk_single_word: assert property (@(posedge sys_clk) disable iff (!rstn)
    busy && !memWaitrequest |=> done && !memReq.read && !memReq.write)
    else $error("transfer not closed after acceptance");

endmodule

// File: design/ced_console.sv
/*
  ced_console: front-panel examine/deposit sequencer top level.
  Holds the console address, drives the address and data displays,
  runs word transfers to memory and offers an Avalon-MM register slave.
  Assumes panel inputs are already synchronous to sys_clk and that the
  memory bus answers every request with waitrequest low at some edge.
*/
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module ced_console
  import ced_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input ced_pkg::ced_keys_t panelKeys,
  input wire logic haltSel,
  input wire logic lockKey,
  input wire logic [ced_pkg::DATA_W-1:0] switchReg,
  output logic consoleOwnsBus,
  output logic [ced_pkg::ADDR_W-1:0] addrDisplay,
  output logic [ced_pkg::DATA_W-1:0] dataDisplay,
  output ced_pkg::ced_mem_req_t memReq,
  input wire logic [ced_pkg::DATA_W-1:0] memReadData,
  input wire logic memWaitrequest,
  input wire logic [ced_pkg::AVS_AW-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [ced_pkg::AVS_DW-1:0] avsWriteData,
  output logic [ced_pkg::AVS_DW-1:0] avsReadData,
  output logic avsWaitrequest
);
  import ced_pkg::*;

  typedef struct packed {
    ced_state_t st;
    ced_op_t lastOp;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dataDisp;
    ced_keys_t prevKeys;
    logic [2:0] softKeys;
    logic own;
    logic softLock;
    logic avsAck;
    logic [AVS_DW-1:0] avsRdata;
  } ced_top_t;

  ced_top_t st_ff;
  ced_top_t nxt_st;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // step size for an address
  function automatic logic [ADDR_W-1:0] stepOf(input logic [ADDR_W-1:0] a);
    stepOf = (a >= REGS_LO && a <= REGS_HI) ? REG_STEP : WORD_STEP;
  endfunction

  // register select
  function automatic logic hit(input logic [AVS_AW-1:0] a, input logic [AVS_AW-1:0] off);
    hit = (a == off);
  endfunction

  logic [2:0] keyEdge;
  logic locked;
  logic canAct;
  logic doLoad;
  logic doDep;
  logic doExam;
  logic repeatOp;
  logic [ADDR_W-1:0] stepAddr;
  logic mstDone;
  logic [DATA_W-1:0] mstData;
  logic avsReq;
  logic busy;

  // ----------------------------------------
  // key decode
  // ----------------------------------------
  // rising key edges from panel or software pulses
  assign keyEdge = (panelKeys & ~st_ff.prevKeys) | st_ff.softKeys;
  assign locked = lockKey | st_ff.softLock;
  assign busy = (st_ff.st != S_IDLE);
  assign canAct = st_ff.own & ~busy & ~locked;
  assign doLoad = canAct & keyEdge[0];
  assign doDep = canAct & ~keyEdge[0] & keyEdge[1];
  assign doExam = canAct & ~keyEdge[0] & ~keyEdge[1] & keyEdge[2];

  // step only when the same operation repeats
  assign repeatOp = (doDep && st_ff.lastOp == OP_DEP) ||
                    (doExam && st_ff.lastOp == OP_EXAMINE_KEY);
  assign stepAddr = repeatOp ? st_ff.addr + stepOf(st_ff.addr) : st_ff.addr;

  // ----------------------------------------
  // memory transfer engine
  // ----------------------------------------
  ced_mem_master uMaster (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(doDep | doExam),
    .writeOp(doDep),
    .reqAddr(stepAddr),
    .reqData(switchReg),
    .done(mstDone),
    .readData(mstData),
    .memReq(memReq),
    .memReadData(memReadData),
    .memWaitrequest(memWaitrequest)
  );

  assign avsReq = avsRead | avsWrite;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.prevKeys = panelKeys;
    nxt_st.softKeys = 3'h0;
    // bus ownership follows the selector between operations
    if (!busy)
    begin
      nxt_st.own = haltSel;
      if (haltSel && !st_ff.own)
      begin
        nxt_st.lastOp = OP_NONE;
      end
    end
    // console sequence
    case (st_ff.st)
      S_IDLE:
      begin
        if (doLoad)
        begin
          nxt_st.addr = switchReg;
          nxt_st.lastOp = OP_NONE;
        end
        else if (doDep)
        begin
          nxt_st.addr = stepAddr;
          nxt_st.dataDisp = switchReg;
          nxt_st.lastOp = OP_DEP;
          nxt_st.st = S_DEP;
        end
        else if (doExam)
        begin
          nxt_st.addr = stepAddr;
          nxt_st.lastOp = OP_EXAMINE_KEY;
          nxt_st.st = S_EXAMINE_KEY;
        end
      end
      S_DEP:
      begin
        if (mstDone)
        begin
          nxt_st.st = S_IDLE;
        end
      end
      S_EXAMINE_KEY:
      begin
        if (mstDone)
        begin
          nxt_st.dataDisp = mstData;
          nxt_st.st = S_IDLE;
        end
      end
      default:
      begin
        nxt_st.st = S_IDLE;
      end
    endcase
    // register slave: one wait state, data latched on the stalled cycle
    nxt_st.avsAck = avsReq & ~st_ff.avsAck;
    if (avsRead && !st_ff.avsAck)
    begin
      nxt_st.avsRdata = '0;
      if (hit(avsAddress, OFF_CTRL))
      begin
        nxt_st.avsRdata[CTRL_LOCK_BIT] = st_ff.softLock;
      end
      else if (hit(avsAddress, OFF_STATUS))
      begin
        nxt_st.avsRdata[STAT_OWN_BIT] = st_ff.own;
        nxt_st.avsRdata[STAT_BUSY_BIT] = busy;
        nxt_st.avsRdata[STAT_LOCK_BIT] = locked;
        nxt_st.avsRdata[STAT_OP_LSB +: 3] = st_ff.lastOp;
      end
      else if (hit(avsAddress, OFF_ADDR))
      begin
        nxt_st.avsRdata[ADDR_W-1:0] = st_ff.addr;
      end
      else if (hit(avsAddress, OFF_DATA))
      begin
        nxt_st.avsRdata[DATA_W-1:0] = st_ff.dataDisp;
      end
      else if (hit(avsAddress, OFF_SWITCH))
      begin
        nxt_st.avsRdata[DATA_W-1:0] = switchReg;
      end
    end
    if (avsWrite && st_ff.avsAck && hit(avsAddress, OFF_CTRL))
    begin
      nxt_st.softLock = avsWriteData[CTRL_LOCK_BIT];
      nxt_st.softKeys = avsWriteData[CTRL_KEY_LSB +: 3];
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff.st <= S_IDLE;
      st_ff.lastOp <= OP_NONE;
      st_ff.addr <= ADDR_RST;
      st_ff.dataDisp <= DATA_RST;
      st_ff.prevKeys <= '0;
      st_ff.softKeys <= 3'h0;
      st_ff.own <= 1'b0;
      st_ff.softLock <= CTRL_LOCK_RST;
      st_ff.avsAck <= 1'b0;
      st_ff.avsRdata <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign consoleOwnsBus = st_ff.own;
  assign addrDisplay = st_ff.addr;
  assign dataDisplay = st_ff.dataDisp;
  assign avsReadData = st_ff.avsRdata;
  assign avsWaitrequest = avsReq & ~st_ff.avsAck;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence depRepeat;
    doDep && st_ff.lastOp == OP_DEP && stepOf(addrDisplay) == WORD_STEP;
  endsequence

  sequence examRepeat;
    doExam && st_ff.lastOp == OP_EXAMINE_KEY;
  endsequence

  sequence freshOp;
    (doDep && st_ff.lastOp != OP_DEP) || (doExam && st_ff.lastOp != OP_EXAMINE_KEY);
  endsequence

  chk_halt_takes_bus: assert property (@(posedge sys_clk) disable iff (!rstn)
    haltSel && !busy |=> consoleOwnsBus)
    else $error("halt selected but console does not own the bus");

  chk_load_copies: assert property (@(posedge sys_clk) disable iff (!rstn)
    doLoad |=> addrDisplay == $past(switchReg) && !memReq.read && !memReq.write)
    else $error("load address did not copy switch register");

  chk_dep_shows: assert property (@(posedge sys_clk) disable iff (!rstn)
    doDep |=> memReq.write && memReq.writeData == $past(switchReg)
      && dataDisplay == $past(switchReg))
    else $error("deposit word or data display wrong");

  chk_dep_step_two: assert property (@(posedge sys_clk) disable iff (!rstn)
    depRepeat |=> memReq.address == $past(addrDisplay) + WORD_STEP)
    else $error("repeated deposit did not step by a word");

  chk_examine_key_reads_word: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_ff.st == S_EXAMINE_KEY && mstDone |=> dataDisplay == $past(mstData) && !busy)
    else $error("examined word not shown");

  chk_examine_key_step: assert property (@(posedge sys_clk) disable iff (!rstn)
    examRepeat |=> memReq.read && addrDisplay == memReq.address
      && memReq.address == $past(addrDisplay) + stepOf($past(addrDisplay)))
    else $error("repeated examine did not step address");

  chk_fresh_no_step: assert property (@(posedge sys_clk) disable iff (!rstn)
    freshOp |=> memReq.address == $past(addrDisplay))
    else $error("first or alternating operation stepped the address");

  chk_reg_step_one: assert property (@(posedge sys_clk) disable iff (!rstn)
    repeatOp && addrDisplay >= REGS_LO && addrDisplay <= REGS_HI
      |=> memReq.address == $past(addrDisplay) + REG_STEP)
    else $error("internal register range not stepped by one");

  chk_lock_ignores: assert property (@(posedge sys_clk) disable iff (!rstn)
    lockKey && !busy |=> $stable(addrDisplay) && !memReq.read && !memReq.write)
    else $error("control key acted while locked");

  chk_avs_one_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
    avsReq && !st_ff.avsAck |-> avsWaitrequest ##1 !avsWaitrequest)
    else $error("register slave wait state wrong");

endmodule

// File: bench/ced_mem_model.sv
/*
  ced_mem_model: word memory behind the sequencer's memory bus.
  Assumes requests are held until accepted; stall cycles set by the bench.
*/
`timescale 1ns/1ps
module ced_mem_model
  import ced_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] stall,
  input ced_pkg::ced_mem_req_t memReq,
  output logic [ced_pkg::DATA_W-1:0] memReadData,
  output logic memWaitrequest
);
  logic [DATA_W-1:0] memArray [0:65535];
  logic [3:0] wait_ff;
  logic gap_ff;
  logic [DATA_W-1:0] last_ff;
  int acceptCnt_ff;
  logic active;
  // ------------------------------------
  // handshake
  // ------------------------------------
  // one accept per request, a dead cycle after it
  assign active = (memReq.read | memReq.write) & ~gap_ff;
  assign memWaitrequest = ~(active & (wait_ff == stall));
  // data lines show the inverted last accepted word outside an accepted transfer
  assign memReadData = memWaitrequest ? ~last_ff : memArray[memReq.address];
  // stall counter and single word write
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_ff <= 4'h0;
      gap_ff <= 1'b0;
      last_ff <= 16'h0000;
      acceptCnt_ff <= 0;
    end
    else
    begin
      gap_ff <= active & ~memWaitrequest;
      if (active & ~memWaitrequest)
      begin
        wait_ff <= 4'h0;
        acceptCnt_ff <= acceptCnt_ff + 1;
        last_ff <= memArray[memReq.address];
        if (memReq.write)
          memArray[memReq.address] <= memReq.writeData;
      end
      else if (active)
        wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule

// File: bench/testbench.sv
/*
  testbench: self-checking bench of the examine/deposit sequencer.
  Assumes ced_console with ced_mem_model on its memory bus.
*/
`timescale 1ns/1ps
module testbench;
  import ced_pkg::*;
  // ------------------------------------
  // signals and instances
  // ------------------------------------
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  ced_keys_t panelKeys = '0;
  logic haltSel = 1'b1;
  logic lockKey = 1'b0;
  logic [DATA_W-1:0] switchReg = 16'h0000;
  logic consoleOwnsBus;
  logic [ADDR_W-1:0] addrDisplay;
  logic [DATA_W-1:0] dataDisplay;
  ced_mem_req_t memReq;
  logic [DATA_W-1:0] memReadData;
  logic memWaitrequest;
  logic [AVS_AW-1:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [AVS_DW-1:0] avsWriteData = 32'h00000000;
  logic [AVS_DW-1:0] avsReadData;
  logic avsWaitrequest;
  logic [3:0] stall = 4'h0;
  logic [15:0] words [3] = '{16'h15c1, 16'h0016, 16'h15c2};
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  ced_console uut (.sys_clk(sys_clk), .rstn(rstn), .panelKeys(panelKeys),
    .haltSel(haltSel), .lockKey(lockKey), .switchReg(switchReg),
    .consoleOwnsBus(consoleOwnsBus), .addrDisplay(addrDisplay),
    .dataDisplay(dataDisplay), .memReq(memReq), .memReadData(memReadData),
    .memWaitrequest(memWaitrequest), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitrequest(avsWaitrequest));
  ced_mem_model model (.sys_clk(sys_clk), .rstn(rstn), .stall(stall),
    .memReq(memReq), .memReadData(memReadData), .memWaitrequest(memWaitrequest));

  // 100 ns clock and hang guard
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      final_report();
    end
  end
  // ------------------------------------
  // shared tasks
  // ------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one register access, held until waitrequest is low
  task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge sys_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWriteData <= wd;
    // waitrequest and read data are taken at the same rising edge
    do
      @(posedge sys_clk);
    while (avsWaitrequest !== 1'b0);
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  // poll status until the sequencer is idle
  task automatic wait_idle();
    logic [31:0] st;
    st = 32'h2;
    while (st[STAT_BUSY_BIT] !== 1'b0)
      avs(1'b0, OFF_STATUS, 32'h0, st);
  endtask
  // key pulse, then wait for the sequencer to go idle
  task automatic press(input int k);
    @(posedge sys_clk);
    panelKeys <= ced_keys_t'(3'(1 << k));
    repeat (2) @(posedge sys_clk);
    panelKeys <= '0;
    wait_idle();
  endtask
  task automatic t_load(input logic [15:0] a);
    switchReg <= a;
    press(0);
    check(addrDisplay, a, "load address");
  endtask
  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic t_power();
    check(consoleOwnsBus, 1'b1, "own at halt");
    haltSel <= 1'b0;
    switchReg <= 16'h0300;
    repeat (2) @(posedge sys_clk);
    check(consoleOwnsBus, 1'b0, "released");
    press(0);
    check(addrDisplay, 16'h0000, "key while running");
    haltSel <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic t_deposits();
    int base;
    base = model.acceptCnt_ff;
    t_load(16'h7744);
    for (int i = 0; i < 3; i++)
    begin
      switchReg <= words[i];
      press(1);
      check(addrDisplay, 16'h7744 + 16'(2 * i), "dep address");
      check(dataDisplay, words[i], "dep display");
      check(model.memArray[16'h7744 + 16'(2 * i)], words[i], "dep memory");
    end
    check(model.acceptCnt_ff - base, 3, "one transfer per deposit");
  endtask
  task automatic t_examine();
    stall <= 4'h3;
    t_load(16'h7744);
    press(2);
    check(addrDisplay, 16'h7744, "first examine_key address");
    check(dataDisplay, words[0], "first examine_key data");
    press(2);
    check(addrDisplay, 16'h7746, "examine_key step");
    check(dataDisplay, words[1], "examine_key step data");
    switchReg <= 16'h1234;
    press(1);
    check(model.memArray[16'h7746], 16'h1234, "dep after examine_key");
    press(2);
    check(addrDisplay, 16'h7746, "examine_key after dep");
    check(dataDisplay, 16'h1234, "examine_key after dep data");
    stall <= 4'h0;
  endtask
  // walk across both edges of the internal register range
  task automatic t_steps();
    logic [15:0] a;
    a = 16'hffbe;
    t_load(a);
    repeat (20)
    begin
      switchReg <= a ^ 16'h0f0f;
      press(1);
      check(addrDisplay, a, "step address");
      check(model.memArray[a], a ^ 16'h0f0f, "step memory");
      a = a + ((a >= REGS_LO && a <= REGS_HI) ? REG_STEP : WORD_STEP);
    end
  endtask
  task automatic t_regbus();
    logic [31:0] rd;
    t_load(16'h0200);
    avs(1'b0, OFF_ADDR, 32'h0, rd);
    check(rd, 32'h00000200, "address register");
    avs(1'b1, OFF_ADDR, 32'h00001111, rd);
    avs(1'b0, OFF_ADDR, 32'h0, rd);
    check(rd, 32'h00000200, "address read-only");
    avs(1'b0, 5'h14, 32'h0, rd);
    check(rd, 32'h00000000, "unmapped read");
    avs(1'b0, OFF_STATUS, 32'h0, rd);
    check(rd[6:0], 7'h11, "status idle");
  endtask
  task automatic t_lock();
    int base;
    logic [31:0] rd;
    base = model.acceptCnt_ff;
    lockKey <= 1'b1;
    switchReg <= 16'h5a5a;
    press(0);
    press(1);
    check(addrDisplay, 16'h0200, "locked load");
    check(model.acceptCnt_ff - base, 0, "locked deposit");
    avs(1'b0, OFF_SWITCH, 32'h0, rd);
    check(rd, 32'h00005a5a, "switch readable");
    lockKey <= 1'b0;
    // software lock blocks keys, then a software deposit pulse
    avs(1'b1, OFF_CTRL, 32'h00000001, rd);
    avs(1'b0, OFF_STATUS, 32'h0, rd);
    check(rd[STAT_LOCK_BIT], 1'b1, "soft lock status");
    press(1);
    check(model.acceptCnt_ff - base, 0, "soft locked deposit");
    avs(1'b1, OFF_CTRL, 32'h00000020, rd);
    wait_idle();
    check(model.memArray[16'h0200], 16'h5a5a, "soft deposit memory");
    check(model.acceptCnt_ff - base, 1, "soft deposit transfer");
    avs(1'b0, OFF_DATA, 32'h0, rd);
    check(rd, 32'h00005a5a, "data register");
    avs(1'b0, OFF_CTRL, 32'h0, rd);
    check(rd, 32'h00000000, "control readback");
  endtask
  // ------------------------------------
  // main sequence
  // ------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_power();
    t_deposits();
    t_examine();
    t_steps();
    t_regbus();
    t_lock();
    final_report();
  end
endmodule
